// ---- rtl/cmb_map.vh ----
// register map, field positions and codes of the can message buffer block
// assumes: included by bare name from the store and top design files of the block; the transmit selector does not include it
`ifndef CMB_MAP_VH
`define CMB_MAP_VH
// global registers, byte offsets inside region 0
`define CMB_A_MODE 6'h00
`define CMB_A_DIR 6'h04
`define CMB_A_REC 6'h08
`define CMB_A_STAT 6'h0c
`define CMB_G_LAST 4'h3
// buffer regions: region 1..2 dedicated rx, 3..8 general, 0x40 bytes each
`define CMB_RGN_LAST 6'h08
`define CMB_FIRST_GEN 3'h2
// word index inside a buffer region
`define CMB_I_CTRL 4'h0
`define CMB_I_IDH 4'h1
`define CMB_I_LAST 4'hb
// writable bits of id low and length code in transmit mode
`define CMB_IDL_TX_MASK 8'heb
`define CMB_DLC_TX_MASK 8'h4f
// error-passive threshold
`define CMB_PASSIVE_LIM 8'h7f
// operating mode codes
`define CMB_MODE_LEGACY 2'h0
// completion status from the protocol engine
`define CMB_ST_OK 2'h0
`define CMB_ST_LARB 2'h1
`define CMB_ST_ERR 2'h2
// control byte bits
`define CMB_B_FULL 7
`define CMB_B_ACCALL 6
`define CMB_B_TX_REQUEST 3
`define CMB_B_AUTO_REMOTE_ANSWER_EN 2
`endif

// ---- rtl/cmb_store.v ----
// id, length code and payload storage of one message buffer
// assumes: load and software write never meet on the same buffer
`timescale 1ns/1ps
`default_nettype none
`include "cmb_map.vh"
module cmb_store (
  input wire core_clk,
  input wire rst_b,
  input wire ld,
  input wire [95:0] ld_all,
  input wire wr,
  input wire [3:0] wr_idx,
  input wire [7:0] wr_data,
  input wire [3:0] rd_idx,
  output wire [7:0] rd_data,
  output wire [87:0] words
);
  wire [87:0] wmask = {{64{1'b1}}, `CMB_DLC_TX_MASK, `CMB_IDL_TX_MASK, 8'hff};
  wire [6:0] wbase = {wr_idx - `CMB_I_IDH, 3'b000};
  wire [6:0] rbase = {rd_idx - `CMB_I_IDH, 3'b000};
  wire rd_ok = (rd_idx >= `CMB_I_IDH) && (rd_idx <= `CMB_I_LAST);
  reg [87:0] st_reg;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= 88'h0;
    end else if (ld) begin
      st_reg <= ld_all[87:0];
    end else if (wr && (wr_idx >= `CMB_I_IDH) && (wr_idx <= `CMB_I_LAST)) begin
      st_reg[wbase +: 8] <= wr_data & wmask[wbase +: 8];
    end
  end
  assign rd_data = rd_ok ? st_reg[rbase +: 8] : 8'h00;
  assign words = st_reg;
endmodule // cmb_store
`default_nettype wire

// ---- rtl/cmb_top.v ----
// can message buffer registers: two dedicated rx buffers, six tx/rx buffers
// assumes: apb master on core_clk, protocol engine signals synchronous
//
// How it works
// - length code 0-8 bytes, 9-15 invalid
// - eight read-only payload bytes per rx buffer
// - error counter readable, passive above 127
// - error counter never causes bus-off
// - six buffers, each tx or rx
// - each buffer in tx mode may auto-answer remote requests
// - six buffers only in enhanced modes
// - full flag blocks loads until software clears
// - accept-all mode ignores filters, takes invalid
// - rx control shows remote request status
// - five-bit filter hit index recorded
// - two-bit priority orders pending transmits
// - priority never alters transmitted identifier
// - id high byte standard or extended bits
// - extended flag marks extended identifier frame
// - direction select bit picks tx or rx
`timescale 1ns/1ps
`default_nettype none
`include "cmb_map.vh"
module cmb_top (
  input wire core_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire pe_rx_valid,
  input wire pe_rx_ok,
  input wire pe_rx_hit,
  input wire [4:0] pe_rx_filt,
  input wire pe_rx_rtr,
  input wire pe_rx_ext,
  input wire pe_rx_srr,
  input wire [28:0] pe_rx_id,
  input wire [3:0] pe_rx_dlc,
  input wire [63:0] pe_rx_data,
  input wire [7:0] pe_rec,
  input wire pe_tx_done,
  input wire [1:0] pe_tx_status,
  output reg pe_tx_req,
  output reg [7:0] pe_tx_idh,
  output reg [7:0] pe_tx_idl,
  output reg [7:0] pe_tx_dlc,
  output reg [63:0] pe_tx_data,
  output reg err_passive
);
  localparam TX_IDLE = 2'b01;
  localparam TX_BUSY = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // global registers
  reg [1:0] mode_reg;
  reg [5:0] dir_reg;
  reg [7:0] rec_reg;
  reg [1:0] tx_state_reg;
  reg [2:0] cur_reg;
  wire enh = (mode_reg != `CMB_MODE_LEGACY);

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire [5:0] rgn = paddr[11:6];
  wire [3:0] idx = paddr[5:2];
  wire in_buf = (rgn != 6'h00) && (rgn <= `CMB_RGN_LAST) && (idx <= `CMB_I_LAST);
  wire in_glob = (rgn == 6'h00) && (idx <= `CMB_G_LAST);
  wire mapped = (in_glob | in_buf) & (paddr[1:0] == 2'b00);
  wire [2:0] bsel = rgn[2:0] - 3'h1;
  wire gen_off = in_buf & (bsel >= `CMB_FIRST_GEN) & ~enh;
  wire acc = psel & penable & ~pready;
  wire wr_cmt = psel & penable & pready & pwrite & mapped;
  wire buf_wr = wr_cmt & in_buf & ~gen_off;
  wire ctrl_wr = buf_wr & (idx == `CMB_I_CTRL);
  wire store_wr = buf_wr & (idx != `CMB_I_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // received frame formatting
  wire [7:0] rx_idh = pe_rx_ext ? pe_rx_id[28:21] : pe_rx_id[10:3];
  wire [7:0] rx_idl = pe_rx_ext ? {pe_rx_id[20:18], pe_rx_srr, 1'b1, 1'b0, pe_rx_id[17:16]}
                                : {pe_rx_id[2:0], 5'h00};
  wire [7:0] rx_dlc = {1'b0, pe_rx_rtr, 2'b00, pe_rx_dlc};
  wire [95:0] rx_all = {8'h00, pe_rx_data, rx_dlc, rx_idl, rx_idh};
  wire rx_good = pe_rx_ok & pe_rx_hit;

  ////////////////////////////////////////////////////////////////////////////
  // per buffer vectors
  wire [7:0] txm;
  wire [7:0] elig;
  wire [7:0] rtr_hit;
  wire [7:0] tx_request_v;
  wire [7:0] pend_v;
  wire [15:0] pri_v;
  wire [63:0] ctrl_rd_v;
  wire [63:0] st_rd_v;
  wire [703:0] words_v;
  reg [7:0] grant;
  wire tx_any;
  wire [2:0] tx_sel;
  wire [2:0] nxt = tx_sel + `CMB_FIRST_GEN;
  wire busy = tx_state_reg[1];

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_buf
      localparam GEN = (i >= 2);
      reg full_reg;
      reg accall_reg;
      reg rtr_reg;
      reg [4:0] filt_reg;
      reg tx_request_reg;
      reg auto_remote_answer_en_reg;
      reg [1:0] pri_reg;
      reg done_reg;
      reg abt_reg;
      reg larb_reg;
      reg err_reg;
      wire [7:0] w_idh = words_v[i*88 +: 8];
      wire [7:0] w_idl = words_v[i*88+8 +: 8];
      wire is_tx;
      wire cw = ctrl_wr & (bsel == i);
      wire fin = busy & pe_tx_done & (cur_reg == i) & tx_request_reg;
      wire fin_ok = fin & (pe_tx_status == `CMB_ST_OK);
      wire new_req = cw & is_tx & pwdata[`CMB_B_TX_REQUEST];
      wire abort_ev = cw & is_tx & ~pwdata[`CMB_B_TX_REQUEST] & tx_request_reg;
      if (GEN) begin : g_gen
        assign is_tx = dir_reg[i-2];
      end else begin : g_ded
        assign is_tx = 1'b0;
      end
      assign txm[i] = is_tx;
      // rx acceptance: full blocks, accept-all skips filters
      assign elig[i] = ~is_tx & ~full_reg & (GEN ? (enh & (accall_reg | rx_good))
                                                 : rx_good);
      // remote request matching this transmit buffer
      assign rtr_hit[i] = pe_rx_valid & pe_rx_ok & pe_rx_rtr & enh & is_tx & auto_remote_answer_en_reg
                          & (w_idh == rx_idh)
                          & ((w_idl & `CMB_IDL_TX_MASK) == (rx_idl & `CMB_IDL_TX_MASK));
      assign tx_request_v[i] = tx_request_reg;
      assign pend_v[i] = is_tx & tx_request_reg & enh;
      assign pri_v[i*2 +: 2] = pri_reg;
      assign ctrl_rd_v[i*8 +: 8] = is_tx ?
        {done_reg, abt_reg, larb_reg, err_reg, tx_request_reg, auto_remote_answer_en_reg, pri_reg} :
        {full_reg, accall_reg, rtr_reg, filt_reg};
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          full_reg <= 1'b0;
          accall_reg <= 1'b0;
          rtr_reg <= 1'b0;
          filt_reg <= 5'h00;
          tx_request_reg <= 1'b0;
          auto_remote_answer_en_reg <= 1'b0;
          pri_reg <= 2'h0;
          done_reg <= 1'b0;
          abt_reg <= 1'b0;
          larb_reg <= 1'b0;
          err_reg <= 1'b0;
        end else begin
          if (grant[i]) begin
            full_reg <= 1'b1;
            rtr_reg <= pe_rx_rtr;
            filt_reg <= pe_rx_filt;
          end else if (cw && !is_tx && !pwdata[`CMB_B_FULL]) begin
            full_reg <= 1'b0;
          end
          if (cw && !is_tx && GEN) begin
            accall_reg <= pwdata[`CMB_B_ACCALL];
          end
          if (cw && is_tx) begin
            auto_remote_answer_en_reg <= pwdata[`CMB_B_AUTO_REMOTE_ANSWER_EN];
            pri_reg <= pwdata[1:0];
          end
          if (rtr_hit[i]) begin
            tx_request_reg <= 1'b1;
          end else if (cw && is_tx) begin
            tx_request_reg <= pwdata[`CMB_B_TX_REQUEST];
          end else if (fin_ok) begin
            tx_request_reg <= 1'b0;
          end
          done_reg <= fin_ok | (done_reg & ~new_req & ~(cw & is_tx & ~pwdata[`CMB_B_FULL]));
          abt_reg <= abort_ev | (abt_reg & ~new_req);
          larb_reg <= (fin & (pe_tx_status == `CMB_ST_LARB)) | (larb_reg & ~new_req);
          err_reg <= (fin & (pe_tx_status == `CMB_ST_ERR)) | (err_reg & ~new_req);
        end
      end
      cmb_store u_store (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .ld(grant[i]),
        .ld_all(rx_all),
        .wr(store_wr & (bsel == i) & is_tx),
        .wr_idx(idx),
        .wr_data(pwdata[7:0]),
        .rd_idx(idx),
        .rd_data(st_rd_v[i*8 +: 8]),
        .words(words_v[i*88 +: 88])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // first eligible buffer takes the frame
  integer k;
  always @* begin
    grant = 8'h00;
    for (k = 7; k >= 0; k = k - 1) begin
      if (pe_rx_valid && elig[k]) begin
        grant = 8'h00;
        grant[k] = 1'b1;
      end
    end
  end

  cmb_txsel u_txsel (
    .pend(pend_v[7:2]),
    .pri(pri_v[15:4]),
    .any(tx_any),
    .sel(tx_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit hand-off to the protocol engine
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state_reg <= TX_IDLE;
      cur_reg <= 3'h0;
      pe_tx_req <= 1'b0;
      pe_tx_idh <= 8'h00;
      pe_tx_idl <= 8'h00;
      pe_tx_dlc <= 8'h00;
      pe_tx_data <= 64'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_any) begin
            cur_reg <= nxt;
            pe_tx_idh <= words_v[nxt*88 +: 8];
            pe_tx_idl <= words_v[nxt*88+8 +: 8];
            pe_tx_dlc <= words_v[nxt*88+16 +: 8];
            pe_tx_data <= words_v[nxt*88+24 +: 64];
            pe_tx_req <= 1'b1;
            tx_state_reg <= TX_BUSY;
          end
        end
        TX_BUSY: begin
          if (pe_tx_done || !tx_request_v[cur_reg]) begin
            pe_tx_req <= 1'b0;
            tx_state_reg <= TX_IDLE;
          end
        end
        default: begin
          pe_tx_req <= 1'b0;
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // error counter and global registers
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rec_reg <= 8'h00;
      err_passive <= 1'b0;
      mode_reg <= `CMB_MODE_LEGACY;
      dir_reg <= 6'h00;
    end else begin
      rec_reg <= pe_rec;
      err_passive <= (pe_rec > `CMB_PASSIVE_LIM);
      if (wr_cmt && in_glob && (paddr[5:0] == `CMB_A_MODE)) begin
        mode_reg <= pwdata[1:0];
      end
      if (wr_cmt && in_glob && (paddr[5:0] == `CMB_A_DIR)) begin
        dir_reg <= pwdata[7:2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and apb answer
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0;
    if (in_glob) begin
      case (paddr[5:0])
        `CMB_A_MODE: rd_word = {30'h0, mode_reg};
        `CMB_A_DIR: rd_word = {24'h0, dir_reg, 2'b00};
        `CMB_A_REC: rd_word = {24'h0, rec_reg};
        `CMB_A_STAT: rd_word = {31'h0, err_passive};
        default: rd_word = 32'h0;
      endcase
    end else if (in_buf && !gen_off) begin
      if (idx == `CMB_I_CTRL) begin
        rd_word = {24'h0, ctrl_rd_v[{bsel, 3'b000} +: 8]};
      end else begin
        rd_word = {24'h0, st_rd_v[{bsel, 3'b000} +: 8]};
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc;
      if (acc) begin
        prdata <= rd_word;
        pslverr <= ~mapped;
      end
    end
  end
endmodule // cmb_top
`default_nettype wire

// ---- rtl/cmb_txsel.v ----
// picks the pending transmit buffer of highest priority level
// assumes: ties go to the lowest buffer index
`timescale 1ns/1ps
`default_nettype none
module cmb_txsel (
  input wire [5:0] pend,
  input wire [11:0] pri,
  output reg any,
  output reg [2:0] sel
);
  reg [1:0] best;
  integer k;
  always @* begin
    any = 1'b0;
    sel = 3'h0;
    best = 2'h0;
    for (k = 0; k < 6; k = k + 1) begin
      if (pend[k] && (!any || (pri[k*2 +: 2] > best))) begin
        any = 1'b1;
        sel = k[2:0];
        best = pri[k*2 +: 2];
      end
    end
  end
endmodule // cmb_txsel
`default_nettype wire

// ---- verification/cmb_pe_model.sv ----
// protocol engine stand-in: delivers received frames, answers transmit offers
// assumes: same clock as the block; status and delay chosen by the bench
`timescale 1ns/1ps
`default_nettype none
module cmb_pe_model (
  input wire logic core_clk,
  input wire logic pe_tx_req,
  input wire logic [7:0] pe_tx_idh,
  input wire logic [1:0] st_cmd,
  input wire logic [7:0] wait_cmd,
  output logic pe_tx_done,
  output logic [1:0] pe_tx_status,
  output logic [7:0] seen_idh,
  output logic pe_rx_valid,
  output logic pe_rx_ok,
  output logic pe_rx_hit,
  output logic [4:0] pe_rx_filt,
  output logic pe_rx_rtr,
  output logic pe_rx_ext,
  output logic pe_rx_srr,
  output logic [28:0] pe_rx_id,
  output logic [3:0] pe_rx_dlc,
  output logic [63:0] pe_rx_data
);
  int n;
  initial begin
    {pe_tx_done, pe_tx_status, seen_idh, pe_rx_valid} = 12'h600;
    {pe_rx_ok, pe_rx_hit, pe_rx_filt, pe_rx_rtr, pe_rx_ext, pe_rx_srr} = 10'h0;
    {pe_rx_id, pe_rx_dlc, pe_rx_data} = 97'h0;
  end
  // one frame, id and payload scrambled once the pulse is over
  task automatic send(input logic ok, hit, rtr, ext, input logic [4:0] filt,
      input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge core_clk);
    pe_rx_valid <= 1'b1;
    {pe_rx_ok, pe_rx_hit, pe_rx_rtr, pe_rx_ext, pe_rx_srr} <= {ok, hit, rtr, ext, ext};
    pe_rx_filt <= filt;
    pe_rx_id <= id;
    pe_rx_dlc <= dlc;
    pe_rx_data <= d;
    @(posedge core_clk);
    pe_rx_valid <= 1'b0;
    pe_rx_id <= ~id;
    pe_rx_data <= ~d;
  endtask
  // answers each offer after wait_cmd cycles unless it is withdrawn
  always begin
    @(posedge core_clk);
    if (pe_tx_req === 1'b1) begin
      seen_idh <= pe_tx_idh;
      n = 0;
      while (n < wait_cmd && pe_tx_req === 1'b1) begin
        @(posedge core_clk);
        n++;
      end
      if (pe_tx_req === 1'b1) begin
        pe_tx_done <= 1'b1;
        pe_tx_status <= st_cmd;
        @(posedge core_clk);
        pe_tx_done <= 1'b0;
        pe_tx_status <= ~st_cmd;
      end
    end
  end
endmodule // cmb_pe_model
`default_nettype wire

// ---- verification/cmb_top_asserts.sv ----
// checker of apb timing, passive flag and transmit offer handshake
// assumes: bound into cmb_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module cmb_top_asserts (
  input wire core_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] pe_rec,
  input wire pe_tx_done,
  input wire pe_tx_req,
  input wire [7:0] pe_tx_idh,
  input wire [7:0] pe_tx_idl,
  input wire [63:0] pe_tx_data,
  input wire err_passive
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access");
  a_unmapped_err: assert property (pready && paddr[11:6] > 6'h08 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_passive_on: assert property (pe_rec > 8'h7f |=> err_passive)
    else $error("passive flag missing");
  a_passive_off: assert property (pe_rec <= 8'h7f |=> !err_passive)
    else $error("passive flag spurious");
  a_offer_hold: assert property (
    pe_tx_req && !pe_tx_done && !(pready && pwrite) && !$past(pready && pwrite) |=> pe_tx_req)
    else $error("offer dropped early");
  a_offer_end: assert property (pe_tx_req && pe_tx_done |=> !pe_tx_req)
    else $error("offer kept after done");
  a_offer_fixed: assert property (
    pe_tx_req ##1 pe_tx_req |-> $stable(pe_tx_idh) && $stable(pe_tx_idl) && $stable(pe_tx_data))
    else $error("offered frame changed");
endmodule // cmb_top_asserts
bind cmb_top cmb_top_asserts cmb_top_asserts_inst (.core_clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pe_rec, .pe_tx_done, .pe_tx_req, .pe_tx_idh, .pe_tx_idl,
  .pe_tx_data, .err_passive);
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench of the can message buffer registers
// assumes: cmb_top, its checker and cmb_pe_model compiled before it
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr, e, err_passive;
  logic pe_rx_valid, pe_rx_ok, pe_rx_hit, pe_rx_rtr, pe_rx_ext, pe_rx_srr, pe_tx_done, pe_tx_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] pe_rec, seen_idh, wait_cmd, pe_tx_idh, pe_tx_idl, pe_tx_dlc;
  logic [1:0] st_cmd, pe_tx_status;
  logic [4:0] pe_rx_filt;
  logic [28:0] pe_rx_id;
  logic [3:0] pe_rx_dlc;
  logic [63:0] pe_rx_data, pe_tx_data;
  logic [28:0] ida = 29'h1abcdef5;
  logic [63:0] da = 64'h8877665544332211;
  int n_errors = 0;
  int n_checks = 0;
  always #25 core_clk = ~core_clk;
  cmb_top cmb_top_inst (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pe_rx_valid, .pe_rx_ok, .pe_rx_hit, .pe_rx_filt, .pe_rx_rtr, .pe_rx_ext,
    .pe_rx_srr, .pe_rx_id, .pe_rx_dlc, .pe_rx_data, .pe_rec, .pe_tx_done, .pe_tx_status,
    .pe_tx_req, .pe_tx_idh, .pe_tx_idl, .pe_tx_dlc, .pe_tx_data, .err_passive);
  cmb_pe_model cmb_pe_model_inst (.core_clk, .pe_tx_req, .pe_tx_idh, .st_cmd, .wait_cmd,
    .pe_tx_done, .pe_tx_status, .seen_idh, .pe_rx_valid, .pe_rx_ok, .pe_rx_hit, .pe_rx_filt,
    .pe_rx_rtr, .pe_rx_ext, .pe_rx_srr, .pe_rx_id, .pe_rx_dlc, .pe_rx_data);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
    if (n >= 20) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), {e, q & {24'hffffff, m}}, {1'b0, 24'h0, x & m});
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pe_tx_done !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_errors++;
      give_verdict();
    end
  endtask
  initial begin
    {core_clk, rst_b, psel, penable, pwrite, paddr, pwdata} = 49'h0;
    {pe_rec, st_cmd, wait_cmd} = 18'h1010a;
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(12'h000, 8'h00, 8'hff);
    rd(12'h004, 8'h00, 8'hff);
    wr(12'h0c0, 8'h40);
    rd(12'h0c0, 8'h00, 8'hff);
    apb(1'b0, 12'h300, 8'h00);
    chk("unmapped", {e, q}, {1'b1, 32'h0});
    pe_rec <= 8'hff;
    rd(12'h008, 8'hff, 8'hff);
    rd(12'h00c, 8'h01, 8'hff);
    pe_rec <= 8'h7f;
    rd(12'h00c, 8'h00, 8'hff);
    $display("test reset and error count done");
    wr(12'h000, 8'h01);
    wr(12'h0c0, 8'h40);
    cmb_pe_model_inst.send(1'b1, 1'b1, 1'b0, 1'b1, 5'h0f, ida, 4'h9, da);
    rd(12'h040, 8'h8f, 8'hff);
    rd(12'h04c, 8'h09, 8'hff);
    rd(12'h044, ida[28:21], 8'hff);
    rd(12'h048, {ida[20:18], 3'b010, ida[17:16]}, 8'heb);
    for (int m = 0; m < 8; m++) begin
      rd(12'h050 + 12'(4 * m), da[8 * m +: 8], 8'hff);
    end
    cmb_pe_model_inst.send(1'b1, 1'b1, 1'b1, 1'b0, 5'h03, 29'h5a3, 4'h0, da);
    rd(12'h08c, 8'h40, 8'hff);
    rd(12'h084, 8'hb4, 8'hff);
    cmb_pe_model_inst.send(1'b1, 1'b1, 1'b1, 1'b0, 5'h07, 29'h5a3, 4'h2, da);
    rd(12'h0c0, 8'he7, 8'hff);
    rd(12'h04c, 8'h09, 8'hff);
    wr(12'h0c0, 8'h40);
    cmb_pe_model_inst.send(1'b0, 1'b0, 1'b0, 1'b0, 5'h01, 29'h5a3, 4'h2, da);
    rd(12'h0c0, 8'hc0, 8'he0);
    rd(12'h100, 8'h00, 8'h80);
    $display("test receive done");
    wr(12'h004, 8'h18);
    wr(12'h104, 8'h11);
    wr(12'h10c, 8'hff);
    rd(12'h10c, 8'h4f, 8'hff);
    wr(12'h144, 8'h22);
    wr(12'h148, 8'h00);
    wr(12'h100, 8'h09);
    wr(12'h140, 8'h0b);
    wait_done();
    st_cmd <= 2'h0;
    rd(12'h100, 8'h28, 8'h28);
    wait_done();
    chk("offered id", {25'h0, seen_idh}, {25'h0, 8'h22});
    wait_done();
    rd(12'h140, 8'h83, 8'hff);
    rd(12'h100, 8'h80, 8'h88);
    chk("offered dlc", {25'h0, pe_tx_dlc}, {25'h0, 8'h4f});
    chk("offered idh", {25'h0, pe_tx_idh}, {25'h0, 8'h11});
    st_cmd <= 2'h2;
    wr(12'h100, 8'h09);
    wait_done();
    rd(12'h100, 8'h18, 8'hf8);
    wr(12'h100, 8'h01);
    rd(12'h100, 8'h50, 8'hf8);
    st_cmd <= 2'h0;
    wait_cmd <= 8'd3;
    wr(12'h140, 8'h04);
    cmb_pe_model_inst.send(1'b1, 1'b1, 1'b1, 1'b0, 5'h02, 29'h110, 4'h0, da);
    wait_done();
    chk("answer id", {25'h0, seen_idh}, {25'h0, 8'h22});
    rd(12'h140, 8'h84, 8'h8c);
    $display("test transmit done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
